//--- hw/pcx_pin_sync.sv
// three-stage synchroniser for the pin inputs, level taken once the last two stages agree
`timescale 1ns/100ps
`default_nettype none
module pcx_pin_sync (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [pcx_pkg::NUM_PINS-1:0] pin_in,
	output logic [pcx_pkg::NUM_PINS-1:0] level_out
);
	genvar i;
	generate
		for (i = 0; i < pcx_pkg::NUM_PINS; i++)
		begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					s1 <= pcx_pkg::SYNC_RST;
					s2 <= pcx_pkg::SYNC_RST;
					s3 <= pcx_pkg::SYNC_RST;
					level_out[i] <= pcx_pkg::SYNC_RST;
				end
				else if (ce_in)
				begin
					s1 <= pin_in[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3)
						level_out[i] <= s3;
				end
			end
		end
	endgenerate
endmodule : pcx_pin_sync
`default_nettype wire

//--- hw/pcx_pkg.sv
// constants, types and register map of the port crossbar and port latches
package pcx_pkg;
	localparam int NUM_PINS = 16;
	localparam int NUM_SIG = 24;
	localparam int PIN_W = 4;
	localparam int CNT_W = 5;
	localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
	localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
	localparam logic [7:0] ADDR_PORT0_MODE = 8'hA4;
	localparam logic [7:0] ADDR_PORT1_MODE = 8'hA5;
	localparam logic [7:0] ADDR_ROUTE_A = 8'hE1;
	localparam logic [7:0] ADDR_ROUTE_B = 8'hE2;
	localparam logic [7:0] ADDR_ROUTE_C = 8'hE3;
	localparam logic [7:0] RST_LATCH = 8'hFF;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] ROUTE_C_MASK = 8'hC1;
	localparam int A_CMP_A = 7;
	localparam int A_COUNT_IN = 6;
	localparam int A_MOD_HI = 5;
	localparam int A_MOD_LO = 3;
	localparam int A_ASYNC = 2;
	localparam int A_SYNC = 1;
	localparam int A_TWO_WIRE = 0;
	localparam logic [2:0] MOD_COUNT_MAX = 3'h5;
	localparam int C_PULLUP_DIS = 7;
	localparam int C_ROUTER_EN = 6;
	localparam int C_CONV_START = 0;
	// signal slots in priority order
	localparam int SIG_SDA = 0;
	localparam int SIG_SCL = 1;
	localparam int SIG_SCK = 2;
	localparam int SIG_MISO = 3;
	localparam int SIG_MOSI = 4;
	localparam int SIG_NSS = 5;
	localparam int SIG_TX = 6;
	localparam int SIG_RX = 7;
	localparam int SIG_MOD0 = 8;
	localparam int SIG_COUNT_IN = 13;
	localparam int SIG_CMP_A = 14;
	localparam int SIG_CMP_B = 15;
	localparam int SIG_TIMER_A = 16;
	localparam int SIG_IRQ_A = 17;
	localparam int SIG_TIMER_B = 18;
	localparam int SIG_IRQ_B = 19;
	localparam int SIG_TIMER_C = 20;
	localparam int SIG_TIMER_C_CAP = 21;
	localparam int SIG_CLK_OUT = 22;
	localparam int SIG_CONV_START = 23;
	localparam int PORT0_PINS = 8;
	localparam logic SYNC_RST = 1'b1;

	typedef struct packed {
		logic valid;
		logic [CNT_W-1:0] sig;
	} pcx_pin_map_t;

	typedef struct packed {
		logic valid;
		logic [PIN_W-1:0] pin;
	} pcx_sig_map_t;
endpackage : pcx_pkg

//--- hw/pcx_top.sv
// port crossbar, port latches and output-mode control for ports 0 and 1
`timescale 1ns/100ps
`default_nettype none
module pcx_top (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic [7:0] SFR_ADDR_IN,
	input wire logic SFR_WR_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	input wire logic SFR_RD_IN,
	input wire logic SFR_RMW_IN,
	input wire logic SFR_BIT_WR_IN,
	input wire logic [2:0] SFR_BIT_SEL_IN,
	input wire logic SFR_BIT_VAL_IN,
	input wire logic [pcx_pkg::NUM_SIG-1:0] PERIPH_OUT_IN,
	input wire logic [pcx_pkg::NUM_SIG-1:0] PERIPH_OE_IN,
	input wire logic [pcx_pkg::NUM_PINS-1:0] PIN_IN,
	output logic [pcx_pkg::NUM_PINS-1:0] PIN_OUT,
	output logic [pcx_pkg::NUM_PINS-1:0] PIN_OE_OUT,
	output logic [pcx_pkg::NUM_PINS-1:0] PULLUP_EN_OUT,
	output logic [pcx_pkg::NUM_SIG-1:0] PERIPH_IN_OUT,
	output logic [7:0] SFR_RDATA_OUT,
	output logic SFR_RVALID_OUT,
	output logic SFR_HIT_OUT
);
	logic [7:0] port0_latch;
	logic [7:0] port1_latch;
	logic [7:0] port0_output_mode;
	logic [7:0] port1_output_mode;
	logic [7:0] route_enable_a;
	logic [7:0] route_enable_b;
	logic [7:0] route_enable_c;
	logic [pcx_pkg::NUM_PINS-1:0] pin_level;
	logic [pcx_pkg::NUM_SIG-1:0] sig_en;
	pcx_pkg::pcx_pin_map_t [pcx_pkg::NUM_PINS-1:0] pin_map;
	pcx_pkg::pcx_sig_map_t [pcx_pkg::NUM_SIG-1:0] sig_map;
	logic router_enable;
	logic pullup_disable;
	logic [2:0] module_signal_count;
	logic [pcx_pkg::NUM_PINS-1:0] latch_all;
	logic [pcx_pkg::NUM_PINS-1:0] mode_all;
	logic [pcx_pkg::NUM_PINS-1:0] next_pin_out;
	logic [pcx_pkg::NUM_PINS-1:0] next_pin_oe;
	logic [pcx_pkg::NUM_PINS-1:0] next_pullup;
	logic [pcx_pkg::NUM_SIG-1:0] next_periph_in;
	logic [7:0] next_rdata;
	logic next_hit;
	logic wr_p0;
	logic wr_p1;
	logic bit_p0;
	logic bit_p1;
	logic wr_mode0;
	logic wr_mode1;
	logic wr_route_a;
	logic wr_route_b;
	logic wr_route_c;
	logic [pcx_pkg::NUM_PINS-1:0] pin_data;
	logic [pcx_pkg::NUM_PINS-1:0] pin_routed;
	logic [pcx_pkg::NUM_PINS-1:0] pin_forced_od;
	logic [pcx_pkg::NUM_PINS-1:0] pin_push_pull;
	logic [pcx_pkg::NUM_PINS-1:0] pin_low;

	// pin inputs come from outside the clock domain
	pcx_pin_sync u_sync (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.pin_in(PIN_IN),
		.level_out(pin_level)
	);

	assign router_enable = route_enable_c[pcx_pkg::C_ROUTER_EN];
	assign pullup_disable = route_enable_c[pcx_pkg::C_PULLUP_DIS];
	assign module_signal_count = route_enable_a[pcx_pkg::A_MOD_HI:pcx_pkg::A_MOD_LO];

	// per-signal enables in priority order; nothing is selected while the router is off
	always_comb
	begin
		sig_en = '0;
		if (router_enable)
		begin
			sig_en[pcx_pkg::SIG_SDA] = route_enable_a[pcx_pkg::A_TWO_WIRE];
			sig_en[pcx_pkg::SIG_SCL] = route_enable_a[pcx_pkg::A_TWO_WIRE];
			sig_en[pcx_pkg::SIG_SCK] = route_enable_a[pcx_pkg::A_SYNC];
			sig_en[pcx_pkg::SIG_MISO] = route_enable_a[pcx_pkg::A_SYNC];
			sig_en[pcx_pkg::SIG_MOSI] = route_enable_a[pcx_pkg::A_SYNC];
			sig_en[pcx_pkg::SIG_NSS] = route_enable_a[pcx_pkg::A_SYNC];
			sig_en[pcx_pkg::SIG_TX] = route_enable_a[pcx_pkg::A_ASYNC];
			sig_en[pcx_pkg::SIG_RX] = route_enable_a[pcx_pkg::A_ASYNC];
			// reserved counts above five route no module signal
			for (int m = 0; m < 5; m++)
			begin
				if (module_signal_count <= pcx_pkg::MOD_COUNT_MAX)
					sig_en[pcx_pkg::SIG_MOD0 + m] = (3'(m) < module_signal_count);
			end
			sig_en[pcx_pkg::SIG_COUNT_IN] = route_enable_a[pcx_pkg::A_COUNT_IN];
			sig_en[pcx_pkg::SIG_CMP_A] = route_enable_a[pcx_pkg::A_CMP_A];
			sig_en[pcx_pkg::SIG_CMP_B] = route_enable_b[0];
			sig_en[pcx_pkg::SIG_TIMER_A] = route_enable_b[1];
			sig_en[pcx_pkg::SIG_IRQ_A] = route_enable_b[2];
			sig_en[pcx_pkg::SIG_TIMER_B] = route_enable_b[3];
			sig_en[pcx_pkg::SIG_IRQ_B] = route_enable_b[4];
			sig_en[pcx_pkg::SIG_TIMER_C] = route_enable_b[5];
			sig_en[pcx_pkg::SIG_TIMER_C_CAP] = route_enable_b[6];
			sig_en[pcx_pkg::SIG_CLK_OUT] = route_enable_b[7];
			sig_en[pcx_pkg::SIG_CONV_START] = route_enable_c[pcx_pkg::C_CONV_START];
		end
	end

	pcx_xbar_decode u_decode (
		.en_in(sig_en),
		.pin_map_out(pin_map),
		.sig_map_out(sig_map)
	);

	assign latch_all = {port1_latch, port0_latch};
	assign mode_all = {port1_output_mode, port0_output_mode};

	// pin drivers: data, enable and weak pull-up per pin
	genvar p;
	generate
		for (p = 0; p < pcx_pkg::NUM_PINS; p++)
		begin : g_pin
			logic [pcx_pkg::CNT_W-1:0] sig;
			assign sig = pin_map[p].sig;
			assign pin_routed[p] = pin_map[p].valid;
			// a routed signal not driven by its peripheral sets the pin data high: released in open-drain, driven high in push-pull
			always_comb
			begin
				pin_data[p] = latch_all[p];
				if (pin_routed[p])
					pin_data[p] = PERIPH_OE_IN[sig] ? PERIPH_OUT_IN[sig] : 1'b1;
			end
			// two-wire lines and serial receive are never driven high on port 0
			always_comb
			begin
				pin_forced_od[p] = 1'b0;
				if (pin_routed[p] && (p < pcx_pkg::PORT0_PINS))
				begin
					if ((sig == pcx_pkg::CNT_W'(pcx_pkg::SIG_SDA)) ||
						(sig == pcx_pkg::CNT_W'(pcx_pkg::SIG_SCL)) ||
						(sig == pcx_pkg::CNT_W'(pcx_pkg::SIG_RX)))
						pin_forced_od[p] = 1'b1;
				end
			end
			assign pin_push_pull[p] = mode_all[p] && !pin_forced_od[p];
			assign pin_low[p] = !pin_data[p];
			always_comb
			begin
				if (!router_enable)
				begin
					// router off: input mode, nothing driven
					next_pin_out[p] = 1'b1;
					next_pin_oe[p] = 1'b0;
					next_pullup[p] = !pullup_disable;
				end
				else if (pin_push_pull[p])
				begin
					next_pin_out[p] = pin_data[p];
					next_pin_oe[p] = 1'b1;
					next_pullup[p] = 1'b0;
				end
				else
				begin
					// open-drain: a one releases the pin, a zero pulls it low
					next_pin_out[p] = 1'b0;
					next_pin_oe[p] = pin_low[p];
					next_pullup[p] = !pullup_disable && !pin_low[p];
				end
			end
		end
	endgenerate

	// peripheral inputs see the synchronised level of their assigned pin, idle high otherwise
	genvar k;
	generate
		for (k = 0; k < pcx_pkg::NUM_SIG; k++)
		begin : g_sig
			always_comb
			begin
				next_periph_in[k] = 1'b1;
				if (sig_map[k].valid)
					next_periph_in[k] = pin_level[sig_map[k].pin];
			end
		end
	endgenerate

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			PIN_OUT <= '1;
		else if (CE_IN)
			PIN_OUT <= next_pin_out;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			PIN_OE_OUT <= '0;
		else if (CE_IN)
			PIN_OE_OUT <= next_pin_oe;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			PULLUP_EN_OUT <= '1;
		else if (CE_IN)
			PULLUP_EN_OUT <= next_pullup;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			PERIPH_IN_OUT <= '1;
		else if (CE_IN)
			PERIPH_IN_OUT <= next_periph_in;
	end

	assign wr_p0 = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_PORT0_LATCH);
	assign wr_p1 = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_PORT1_LATCH);
	assign bit_p0 = SFR_BIT_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_PORT0_LATCH);
	assign bit_p1 = SFR_BIT_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_PORT1_LATCH);
	// byte write decodes, one per configuration register
	assign wr_mode0 = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_PORT0_MODE);
	assign wr_mode1 = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_PORT1_MODE);
	assign wr_route_a = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_ROUTE_A);
	assign wr_route_b = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_ROUTE_B);
	assign wr_route_c = SFR_WR_IN && (SFR_ADDR_IN == pcx_pkg::ADDR_ROUTE_C);

	// port latches: a byte write wins over a bit write in the same cycle
	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			port0_latch <= pcx_pkg::RST_LATCH;
		else if (CE_IN)
		begin
			if (wr_p0)
				port0_latch <= SFR_WDATA_IN;
			else if (bit_p0)
				port0_latch[SFR_BIT_SEL_IN] <= SFR_BIT_VAL_IN;
		end
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			port1_latch <= pcx_pkg::RST_LATCH;
		else if (CE_IN)
		begin
			if (wr_p1)
				port1_latch <= SFR_WDATA_IN;
			else if (bit_p1)
				port1_latch[SFR_BIT_SEL_IN] <= SFR_BIT_VAL_IN;
		end
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			port0_output_mode <= pcx_pkg::RST_MODE;
		else if (CE_IN && wr_mode0)
			port0_output_mode <= SFR_WDATA_IN;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			port1_output_mode <= pcx_pkg::RST_MODE;
		else if (CE_IN && wr_mode1)
			port1_output_mode <= SFR_WDATA_IN;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			route_enable_a <= pcx_pkg::RST_ROUTE;
		else if (CE_IN && wr_route_a)
			route_enable_a <= SFR_WDATA_IN;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			route_enable_b <= pcx_pkg::RST_ROUTE;
		else if (CE_IN && wr_route_b)
			route_enable_b <= SFR_WDATA_IN;
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			route_enable_c <= pcx_pkg::RST_ROUTE;
		else if (CE_IN && wr_route_c)
			route_enable_c <= SFR_WDATA_IN & pcx_pkg::ROUTE_C_MASK;
	end

	// read mux: ports return pins, read-modify-write returns the latch
	always_comb
	begin
		next_rdata = 8'h00;
		next_hit = 1'b1;
		unique case (SFR_ADDR_IN)
			pcx_pkg::ADDR_PORT0_LATCH:
				next_rdata = SFR_RMW_IN ? port0_latch : pin_level[7:0];
			pcx_pkg::ADDR_PORT1_LATCH:
				next_rdata = SFR_RMW_IN ? port1_latch : pin_level[15:8];
			pcx_pkg::ADDR_PORT0_MODE:
				next_rdata = port0_output_mode;
			pcx_pkg::ADDR_PORT1_MODE:
				next_rdata = port1_output_mode;
			pcx_pkg::ADDR_ROUTE_A:
				next_rdata = route_enable_a;
			pcx_pkg::ADDR_ROUTE_B:
				next_rdata = route_enable_b;
			pcx_pkg::ADDR_ROUTE_C:
				next_rdata = route_enable_c & pcx_pkg::ROUTE_C_MASK;
			default:
				next_hit = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			SFR_RVALID_OUT <= 1'b0;
			SFR_HIT_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			SFR_RVALID_OUT <= SFR_RD_IN;
			SFR_HIT_OUT <= SFR_RD_IN && next_hit;
		end
	end

	// read data holds until the next read strobe
	always_ff @(posedge MCLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			SFR_RDATA_OUT <= 8'h00;
		else if (CE_IN && SFR_RD_IN)
			SFR_RDATA_OUT <= next_rdata;
	end
endmodule : pcx_top
`default_nettype wire

//--- hw/pcx_xbar_decode.sv
// priority decoder: enabled signals take consecutive pins from pin 0 upward
`timescale 1ns/100ps
`default_nettype none
module pcx_xbar_decode (
	input wire logic [pcx_pkg::NUM_SIG-1:0] en_in,
	output pcx_pkg::pcx_pin_map_t [pcx_pkg::NUM_PINS-1:0] pin_map_out,
	output pcx_pkg::pcx_sig_map_t [pcx_pkg::NUM_SIG-1:0] sig_map_out
);
	logic [pcx_pkg::CNT_W-1:0] slot [0:pcx_pkg::NUM_SIG];
	assign slot[0] = '0;
	genvar k;
	genvar p;
	generate
		for (k = 0; k < pcx_pkg::NUM_SIG; k++)
		begin : g_sig
			// slot of a signal is the count of enabled signals ahead of it
			assign slot[k+1] = slot[k] + {{(pcx_pkg::CNT_W-1){1'b0}}, en_in[k]};
			// signals pushed past the last crossbar pin stay unconnected
			assign sig_map_out[k].valid = en_in[k] &&
				(slot[k] < pcx_pkg::CNT_W'(pcx_pkg::NUM_PINS));
			assign sig_map_out[k].pin = slot[k][pcx_pkg::PIN_W-1:0];
		end
		for (p = 0; p < pcx_pkg::NUM_PINS; p++)
		begin : g_pin
			always_comb
			begin
				pin_map_out[p] = '0;
				for (int j = 0; j < pcx_pkg::NUM_SIG; j++)
				begin
					if (en_in[j] && (slot[j] == pcx_pkg::CNT_W'(p)))
					begin
						pin_map_out[p].valid = 1'b1;
						pin_map_out[p].sig = pcx_pkg::CNT_W'(j);
					end
				end
			end
		end
	endgenerate
endmodule : pcx_xbar_decode
`default_nettype wire

//--- verification/pcx_pin_env.sv
// pins and board circuitry on the far side of the crossbar
`timescale 1ns/100ps
`default_nettype none
module pcx_pin_env (
	input wire logic clk_in,
	input wire logic [pcx_pkg::NUM_PINS-1:0] out_in,
	input wire logic [pcx_pkg::NUM_PINS-1:0] oe_in,
	input wire logic [pcx_pkg::NUM_PINS-1:0] pu_in,
	input wire logic [pcx_pkg::NUM_PINS-1:0] ext_en_in,
	input wire logic [pcx_pkg::NUM_PINS-1:0] ext_val_in,
	output logic [pcx_pkg::NUM_PINS-1:0] level_out
);
	logic flt = 1'b0;
	always_ff @(posedge clk_in)
		flt <= !flt;
	// undriven and unpulled pins wander instead of holding a value
	always_comb
		for (int i = 0; i < pcx_pkg::NUM_PINS; i++)
			level_out[i] = oe_in[i] ? out_in[i] : ext_en_in[i] ? ext_val_in[i] : pu_in[i] | flt;
endmodule : pcx_pin_env
`default_nettype wire

//--- verification/pcx_top_monitor.sv
// concurrent checks on the crossbar top ports
`timescale 1ns/100ps
`default_nettype none
module pcx_top_monitor (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic [7:0] SFR_ADDR_IN,
	input wire logic SFR_WR_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	input wire logic SFR_RD_IN,
	input wire logic [pcx_pkg::NUM_SIG-1:0] PERIPH_OUT_IN,
	input wire logic [pcx_pkg::NUM_SIG-1:0] PERIPH_OE_IN,
	input wire logic [pcx_pkg::NUM_PINS-1:0] PIN_OUT,
	input wire logic [pcx_pkg::NUM_PINS-1:0] PIN_OE_OUT,
	input wire logic [pcx_pkg::NUM_PINS-1:0] PULLUP_EN_OUT,
	input wire logic [7:0] SFR_RDATA_OUT,
	input wire logic SFR_RVALID_OUT,
	input wire logic SFR_HIT_OUT
);
	logic [7:0] route_a;
	logic [7:0] route_c;
	logic rd_map;
	default clocking @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);
	assign rd_map = SFR_ADDR_IN inside {8'h80, 8'h90, 8'hA4, 8'hA5, 8'hE1, 8'hE2, 8'hE3};
	// shadow of routing registers A and C
	always_ff @(posedge MCLK_IN or posedge RST_IN)
		if (RST_IN)
		begin
			route_a <= 8'h00;
			route_c <= 8'h00;
		end
		else if (CE_IN && SFR_WR_IN)
		begin
			if (SFR_ADDR_IN == pcx_pkg::ADDR_ROUTE_A)
				route_a <= SFR_WDATA_IN;
			if (SFR_ADDR_IN == pcx_pkg::ADDR_ROUTE_C)
				route_c <= SFR_WDATA_IN;
		end
	rd_valid_a:
		assert property (CE_IN |=> SFR_RVALID_OUT == $past(SFR_RD_IN))
		else $error("read answer not one cycle after strobe");
	rd_hit_a:
		assert property (CE_IN && SFR_RD_IN |=> SFR_HIT_OUT == $past(rd_map))
		else $error("hit flag wrong for address");
	route_c_read_a:
		assert property (CE_IN && SFR_RD_IN && SFR_ADDR_IN == pcx_pkg::ADDR_ROUTE_C
			|=> SFR_RDATA_OUT == ($past(route_c) & pcx_pkg::ROUTE_C_MASK))
		else $error("third routing register read wrong");
	drive_pullup_a:
		assert property ((PIN_OE_OUT & PULLUP_EN_OUT) == '0)
		else $error("pull-up on while pin driven");
	router_off_a:
		assert property (CE_IN && !route_c[6] |=> PIN_OE_OUT == '0 && PIN_OUT == '1)
		else $error("pin driven with router off");
	pullup_idle_a:
		assert property (CE_IN && route_c[7:6] == 2'b00 |=> PULLUP_EN_OUT == '1)
		else $error("pull-ups missing with router off");
	pullup_dis_a:
		assert property (CE_IN && route_c[7] |=> PULLUP_EN_OUT == '0)
		else $error("pull-up on while disabled");
	two_wire_a:
		assert property (CE_IN && route_c[6] && route_a[0] |=> PIN_OUT[1:0] == 2'b00
			&& PIN_OE_OUT[1:0] == $past(PERIPH_OE_IN[1:0] & ~PERIPH_OUT_IN[1:0]))
		else $error("two-wire pins not open-drain on peripheral data");
endmodule : pcx_top_monitor
bind pcx_top pcx_top_monitor u_mon (.MCLK_IN, .RST_IN, .CE_IN, .SFR_ADDR_IN, .SFR_WR_IN,
	.SFR_WDATA_IN, .SFR_RD_IN, .PERIPH_OUT_IN, .PERIPH_OE_IN, .PIN_OUT, .PIN_OE_OUT,
	.PULLUP_EN_OUT, .SFR_RDATA_OUT, .SFR_RVALID_OUT, .SFR_HIT_OUT);
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the port crossbar block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic [23:0] periph_in;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rmw = 1'b0;
	logic bwr = 1'b0;
	logic [2:0] bsel = 3'h0;
	logic bval = 1'b0;
	logic [23:0] p_out = 24'h000000;
	logic [23:0] p_oe = 24'h000000;
	logic [15:0] ext_en = 16'h0000;
	logic [15:0] ext_val = 16'h0000;
	logic [15:0] lvl, pout, poe, pu;
	logic [7:0] rdata;
	logic rvalid, hit;
	int n_fail = 0;
	int checked = 0;
	// route_a, route_b, route_c, pin data, pin enable
	logic [55:0] rows [14] = '{
		56'h010040_0000_FFFC,
		56'h020040_000F_FFFF,
		56'h040040_0001_FFFD,
		56'h070040_007C_FF7C,
		56'h280040_001F_FFFF,
		56'h180040_0007_FFFF,
		56'h300040_0000_FFFF,
		56'h800040_0001_FFFF,
		56'h400040_0001_FFFF,
		56'h00FF40_00FF_FFFF,
		56'h00007F_0001_FFFF,
		56'hFFFF41_FF7C_FF7C,
		56'h010000_FFFF_0000,
		56'hFFFFC1_FF7C_FF7C};
	// address and reset value; last one is unmapped
	logic [15:0] rst_rows [8] = '{16'h80FF, 16'h90FF, 16'hA400, 16'hA500,
		16'hE100, 16'hE200, 16'hE300, 16'h5500};
	pcx_top dut (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .SFR_ADDR_IN(addr),
		.SFR_WR_IN(wr), .SFR_WDATA_IN(wdata), .SFR_RD_IN(rd), .SFR_RMW_IN(rmw),
		.SFR_BIT_WR_IN(bwr), .SFR_BIT_SEL_IN(bsel), .SFR_BIT_VAL_IN(bval),
		.PERIPH_OUT_IN(p_out), .PERIPH_OE_IN(p_oe), .PIN_IN(lvl), .PIN_OUT(pout),
		.PIN_OE_OUT(poe), .PULLUP_EN_OUT(pu), .PERIPH_IN_OUT(periph_in), .SFR_RDATA_OUT(rdata),
		.SFR_RVALID_OUT(rvalid), .SFR_HIT_OUT(hit));
	pcx_pin_env env (.clk_in(clk), .out_in(pout), .oe_in(poe), .pu_in(pu),
		.ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
	always #5 clk = ~clk;
	task automatic cmp(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask : wr_reg
	task automatic bit_wr(input logic [7:0] a, input logic [2:0] s, input logic v);
		@(posedge clk);
		#1 addr = a;
		bsel = s;
		bval = v;
		bwr = 1'b1;
		@(posedge clk);
		#1 bwr = 1'b0;
	endtask : bit_wr
	task automatic rd_reg(input logic [7:0] a, input logic m, input logic [7:0] exp);
		@(posedge clk);
		#1 addr = a;
		rd = 1'b1;
		rmw = m;
		@(posedge clk);
		#1 rd = 1'b0;
		rmw = 1'b0;
		cmp("rvalid", {15'h0, rvalid}, 16'h0001);
		cmp("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask : rd_reg
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_clk
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		#100000;
		n_fail++;
		close_out();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		cmp("rst_pins", pout & ~poe, 16'hFFFF);
		foreach (rst_rows[i])
			rd_reg(rst_rows[i][15:8], 1'b0, rst_rows[i][7:0]);
		cmp("hit", {15'h0, hit}, 16'h0000);
		rd_reg(pcx_pkg::ADDR_PORT0_LATCH, 1'b1, 8'hFF);
		$display("reset test done");
		wr_reg(pcx_pkg::ADDR_PORT0_LATCH, 8'h00);
		wr_reg(pcx_pkg::ADDR_PORT1_LATCH, 8'h00);
		wr_reg(pcx_pkg::ADDR_PORT0_MODE, 8'hFF);
		wr_reg(pcx_pkg::ADDR_PORT1_MODE, 8'hFF);
		foreach (rows[i])
		begin
			wr_reg(pcx_pkg::ADDR_ROUTE_A, rows[i][55:48]);
			wr_reg(pcx_pkg::ADDR_ROUTE_B, rows[i][47:40]);
			wr_reg(pcx_pkg::ADDR_ROUTE_C, rows[i][39:32]);
			wait_clk(3);
			cmp("pin_out", pout, rows[i][31:16]);
			cmp("pin_oe", poe, rows[i][15:0]);
			cmp("pullup", pu, rows[i][39] ? 16'h0 : rows[i][38] ? ~rows[i][15:0] : 16'hFFFF);
			rd_reg(pcx_pkg::ADDR_ROUTE_C, 1'b0, rows[i][39:32] & pcx_pkg::ROUTE_C_MASK);
			$display("row %0d done", i);
		end
		wr_reg(pcx_pkg::ADDR_ROUTE_C, 8'h00);
		wait_clk(6);
		rd_reg(pcx_pkg::ADDR_PORT0_LATCH, 1'b0, 8'hFF);
		rd_reg(pcx_pkg::ADDR_PORT0_LATCH, 1'b1, 8'h00);
		bit_wr(pcx_pkg::ADDR_PORT1_LATCH, 3'h3, 1'b1);
		rd_reg(pcx_pkg::ADDR_PORT1_LATCH, 1'b1, 8'h08);
		$display("latch test done");
		wr_reg(pcx_pkg::ADDR_ROUTE_A, 8'h00);
		wr_reg(pcx_pkg::ADDR_ROUTE_B, 8'h00);
		wr_reg(pcx_pkg::ADDR_PORT0_MODE, 8'h0F);
		wr_reg(pcx_pkg::ADDR_PORT0_LATCH, 8'h35);
		wr_reg(pcx_pkg::ADDR_ROUTE_C, 8'h40);
		wait_clk(3);
		cmp("mode_out", pout & 16'h00FF, 16'h0005);
		cmp("mode_oe", poe & 16'h00FF, 16'h00CF);
		cmp("mode_pu", pu & 16'h00FF, 16'h0030);
		ext_en = 16'h0010;
		wait_clk(8);
		rd_reg(pcx_pkg::ADDR_PORT0_LATCH, 1'b0, 8'h25);
		$display("mode test done");
		p_oe = 24'h000001;
		wr_reg(pcx_pkg::ADDR_ROUTE_A, 8'h01);
		wait_clk(3);
		cmp("sda_oe", poe & 16'h0003, 16'h0001);
		cmp("sda_out", pout & 16'h0003, 16'h0000);
		wait_clk(4);
		cmp("periph_in_lo", periph_in[15:0], 16'hFFFE);
		cmp("periph_in_hi", {8'h00, periph_in[23:16]}, 16'h00FF);
		$display("peripheral drive test done");
		ce = 1'b0;
		wr_reg(pcx_pkg::ADDR_PORT1_LATCH, 8'h55);
		ce = 1'b1;
		rd_reg(pcx_pkg::ADDR_PORT1_LATCH, 1'b1, 8'h08);
		$display("clock enable test done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
